// ==== synth_consts.svh ====
// Purpose: constants of the serial programming and tuning block
// Assumes: frame is shifted data first, address last
// Notes:   included by the package and the design modules
`ifndef SYNTH_CONSTS_SVH
`define SYNTH_CONSTS_SVH

// ************************************************************
// frame layout
// ************************************************************
`define FRAME_BITS      22
`define DATA_BITS       18
`define ADDR_BITS       4
`define ADDR_LSB        0
`define DATA_LSB        4

// ************************************************************
// register addresses
// ************************************************************
`define REG_MAIN        4'h0
`define REG_GAIN        4'h1
`define REG_PWR         4'h2
`define REG_N_RF1       4'h3
`define REG_N_RF2       4'h4
`define REG_N_IF        4'h5
`define REG_R_RF1       4'h6
`define REG_R_RF2       4'h7
`define REG_R_IF        4'h8
`define REG_COUNT       9
`define REG_IMPL_MASK   16'h01FF
`define REG_RESET       18'h00000

// ************************************************************
// field positions
// ************************************************************
`define MAIN_AUTOPD_BIT 3
`define MAIN_IFDIV_LSB  10
`define MAIN_AUXSEL_LSB 12
`define PWR_RF_BIT      0
`define PWR_IF_BIT      1
`define AUXSEL_LOCKWARN 2'h1

// ************************************************************
// timing in phase detector update periods
// ************************************************************
`define TUNE_PERIODS    6'h0D
`define SETTLE_PERIODS  6'h28

`endif

// ==== synth_pkg.sv ====
// Purpose: types of the serial programming and tuning block
// Assumes: constants come from synth_consts.svh
// Notes:   types only
`include "synth_consts.svh"
package synth_pkg;

    typedef enum logic [3:0] {
        ST_OFF  = 4'h1,
        ST_TUNE = 4'h2,
        ST_LOOP = 4'h4,
        ST_LOCK = 4'h8
    } tuneState_t;

    typedef logic [`FRAME_BITS-1:0] frame_t;
    typedef logic [`DATA_BITS-1:0]  regData_t;
    typedef logic [5:0]             periodCnt_t;

endpackage : synth_pkg

// ==== tune_if.sv ====
// Purpose: carrier between the top and one tuning sequencer
// Assumes: all signals on sys_clk
// Notes:   start and tick are one-cycle pulses
`timescale 1ns/100ps
interface tune_if;
    logic start;
    logic powered;
    logic tick;
    logic tuning;
    logic loopClosed;
    logic settled;

    modport seq (input start, input powered, input tick,
                 output tuning, output loopClosed, output settled);
    modport ctl (output start, output powered, output tick,
                 input tuning, input loopClosed, input settled);
endinterface : tune_if

// ==== pll_tune_seq.sv ====
// Purpose: self-tuning then closed-loop sequence of one PLL
// Assumes: tick marks one phase detector update period
// Notes:   powering down aborts any sequence
`timescale 1ns/100ps
`include "synth_consts.svh"
module pll_tune_seq
    import synth_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    tune_if.seq       tp
);
    tuneState_t state_ff;
    periodCnt_t cnt_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_OFF;
            cnt_ff   <= 6'h00;
        end else if (clkEn) begin
            if (!tp.powered) begin
                state_ff <= ST_OFF;
                cnt_ff   <= 6'h00;
            end else if (tp.start) begin
                state_ff <= ST_TUNE;
                cnt_ff   <= 6'h00;
            end else begin
                case (state_ff)
                    ST_TUNE: begin
                        if (tp.tick) begin
                            cnt_ff <= cnt_ff + 6'h01;
                            if (cnt_ff == `TUNE_PERIODS - 6'h01) begin
                                state_ff <= ST_LOOP;
                            end
                        end
                    end
                    ST_LOOP: begin
                        if (tp.tick) begin
                            cnt_ff <= cnt_ff + 6'h01;
                            if (cnt_ff == `SETTLE_PERIODS - 6'h01) begin
                                state_ff <= ST_LOCK;
                            end
                        end
                    end
                    ST_OFF, ST_LOCK: ;
                    default: state_ff <= ST_OFF;
                endcase
            end
        end
    end

    assign tp.tuning     = state_ff[1];
    assign tp.loopClosed = state_ff[2] | state_ff[3];
    assign tp.settled    = state_ff[3];

    // ************************************************************
    // checks
    // ************************************************************
    AST_TUNE_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n || !clkEn)
        state_ff == ST_TUNE && tp.tick && cnt_ff == 6'h0C && tp.powered && !tp.start
        |=> state_ff == ST_LOOP)
        else $error("tuning did not end after its periods");
    AST_CLOSED: assert property (@(posedge sys_clk) disable iff (!rst_n || !clkEn)
        $fell(tp.tuning) && tp.powered && !tp.start |-> tp.loopClosed && cnt_ff == 6'h0D)
        else $error("loop not closed after tuning");
    COV_SETTLED: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(tp.settled));

endmodule : pll_tune_seq

// ==== synth_serial_program_and_tune.sv ====
// Purpose: serial programming port, PLL selection, tuning and lock warning
// Assumes: shiftClk runs outside a frame only while the strobe is high
// Notes:   frame commits in the sys_clk domain after the strobe rises
`timescale 1ns/100ps
`include "synth_consts.svh"
module synth_serial_program_and_tune
    import synth_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    input  wire logic       shiftClk,
    input  wire logic       serial_in_line,
    input  wire logic       word_latch_strobe_n,
    input  wire logic       sleep_pin_n,
    input  wire logic       updateTick,
    input  wire logic       ifNearLimit,
    input  wire logic       rfNearLimit,
    output logic            rfSelect,
    output logic            rfPowered,
    output logic            ifPowered,
    output logic [1:0]      ifDivSel,
    output logic            rfTuning,
    output logic            ifTuning,
    output logic            rfLoopClosed,
    output logic            ifLoopClosed,
    output logic            lock_warning_n,
    output logic            auxiliary_pin
);
    // ************************************************************
    // link domain shift register
    // ************************************************************
    frame_t linkShift_ff;

    always_ff @(posedge shiftClk or negedge rst_n) begin
        if (!rst_n) begin
            linkShift_ff <= '0;
        end else if (!word_latch_strobe_n) begin
            linkShift_ff <= {linkShift_ff[`FRAME_BITS-2:0], serial_in_line};
        end
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic strobeMeta_ff;
    logic strobeSync_ff;
    logic strobeDly_ff;
    logic sleepMeta_ff;
    logic sleepSync_ff;
    logic [1:0] limitMeta_ff;
    logic [1:0] limitSync_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobeMeta_ff <= 1'b1;
            strobeSync_ff <= 1'b1;
            strobeDly_ff  <= 1'b1;
            sleepMeta_ff  <= 1'b0;
            sleepSync_ff  <= 1'b0;
            limitMeta_ff  <= 2'h0;
            limitSync_ff  <= 2'h0;
        end else if (clkEn) begin
            strobeMeta_ff <= word_latch_strobe_n;
            strobeSync_ff <= strobeMeta_ff;
            strobeDly_ff  <= strobeSync_ff;
            sleepMeta_ff  <= sleep_pin_n;
            sleepSync_ff  <= sleepMeta_ff;
            limitMeta_ff  <= {rfNearLimit, ifNearLimit};
            limitSync_ff  <= limitMeta_ff;
        end
    end

    // ************************************************************
    // frame commit
    // ************************************************************
    logic   commit;
    frame_t frameWord_ff;
    logic   frameValid_ff;

    assign commit = strobeSync_ff & ~strobeDly_ff;

    // shift register is quiet while the strobe is high, so the word is stable here
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frameWord_ff  <= '0;
            frameValid_ff <= 1'b0;
        end else if (clkEn) begin
            frameValid_ff <= commit;
            if (commit) begin
                frameWord_ff <= linkShift_ff;
            end
        end
    end

    // ************************************************************
    // data registers
    // ************************************************************
    logic [`ADDR_BITS-1:0] wrAddr;
    regData_t              wrData;
    logic [15:0]           wrHot;
    regData_t              regFile_ff [0:`REG_COUNT-1];

    assign wrAddr = frameWord_ff[`ADDR_LSB +: `ADDR_BITS];
    assign wrData = frameWord_ff[`DATA_LSB +: `DATA_BITS];
    assign wrHot  = frameValid_ff ? ((16'h0001 << wrAddr) & `REG_IMPL_MASK) : 16'h0000;

    // writes are taken whatever the power state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                regFile_ff[i] <= `REG_RESET;
            end
        end else if (clkEn) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                if (wrHot[i]) begin
                    regFile_ff[i] <= wrData;
                end
            end
        end
    end

    // ************************************************************
    // RF selection, power and tuning starts
    // ************************************************************
    logic rfSel_ff;
    logic rfPow_ff;
    logic ifPow_ff;
    logic rfStart_ff;
    logic ifStart_ff;
    logic [1:0] ifDiv_ff;
    logic nxt_rfPow;
    logic nxt_ifPow;
    logic wrRf1;
    logic wrRf2;
    logic wrIf;

    assign wrRf1 = wrHot[`REG_N_RF1] | wrHot[`REG_R_RF1];
    assign wrRf2 = wrHot[`REG_N_RF2] | wrHot[`REG_R_RF2];
    assign wrIf  = wrHot[`REG_N_IF]  | wrHot[`REG_R_IF];

    assign nxt_rfPow = sleepSync_ff & (regFile_ff[`REG_PWR][`PWR_RF_BIT]
                     | regFile_ff[`REG_MAIN][`MAIN_AUTOPD_BIT]);
    assign nxt_ifPow = sleepSync_ff & (regFile_ff[`REG_PWR][`PWR_IF_BIT]
                     | regFile_ff[`REG_MAIN][`MAIN_AUTOPD_BIT]);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rfSel_ff <= 1'b0;
        end else if (clkEn) begin
            if (wrRf2) begin
                rfSel_ff <= 1'b1;
            end else if (wrRf1) begin
                rfSel_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rfPow_ff   <= 1'b0;
            ifPow_ff   <= 1'b0;
            rfStart_ff <= 1'b0;
            ifStart_ff <= 1'b0;
        end else if (clkEn) begin
            rfPow_ff   <= nxt_rfPow;
            ifPow_ff   <= nxt_ifPow;
            rfStart_ff <= (nxt_rfPow & ~rfPow_ff) | wrRf1 | wrRf2;
            ifStart_ff <= (nxt_ifPow & ~ifPow_ff) | wrIf;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ifDiv_ff <= 2'h0;
        end else if (clkEn) begin
            ifDiv_ff <= regFile_ff[`REG_MAIN][`MAIN_IFDIV_LSB +: 2];
        end
    end

    // ************************************************************
    // tuning sequencers
    // ************************************************************
    tune_if rfTp ();
    tune_if ifTp ();

    assign rfTp.start   = rfStart_ff;
    assign rfTp.powered = rfPow_ff;
    assign rfTp.tick    = updateTick;
    assign ifTp.start   = ifStart_ff;
    assign ifTp.powered = ifPow_ff;
    assign ifTp.tick    = updateTick;

    pll_tune_seq u_rfSeq (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .tp      (rfTp.seq)
    );

    pll_tune_seq u_ifSeq (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .tp      (ifTp.seq)
    );

    // ************************************************************
    // lock warning and auxiliary pin
    // ************************************************************
    logic warn_ff;
    logic aux_ff;
    logic nxt_warn;

    // high until a loop closes, while tuning, or near range limit
    assign nxt_warn = rfTp.tuning | ifTp.tuning
                    | (limitSync_ff[0] & ifTp.loopClosed)
                    | (limitSync_ff[1] & rfTp.loopClosed)
                    | ~(rfTp.loopClosed | ifTp.loopClosed);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            warn_ff <= 1'b1;
            aux_ff  <= 1'b0;
        end else if (clkEn) begin
            warn_ff <= nxt_warn;
            aux_ff  <= (regFile_ff[`REG_MAIN][`MAIN_AUXSEL_LSB +: 2] == `AUXSEL_LOCKWARN)
                     & warn_ff;
        end
    end

    assign rfSelect       = rfSel_ff;
    assign rfPowered      = rfPow_ff;
    assign ifPowered      = ifPow_ff;
    assign ifDivSel       = ifDiv_ff;
    assign rfTuning       = rfTp.tuning;
    assign ifTuning       = ifTp.tuning;
    assign rfLoopClosed   = rfTp.loopClosed;
    assign ifLoopClosed   = ifTp.loopClosed;
    assign lock_warning_n = warn_ff;
    assign auxiliary_pin  = aux_ff;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clkEn);

    AST_SHIFT: assert property (@(posedge shiftClk) disable iff (!rst_n)
        !word_latch_strobe_n |=> linkShift_ff[0] == $past(serial_in_line))
        else $error("serial bit not shifted in");
    AST_HOLD: assert property (@(posedge shiftClk) disable iff (!rst_n)
        word_latch_strobe_n |=> $stable(linkShift_ff))
        else $error("shift register moved while strobe high");
    AST_LAST22: assert property (@(posedge shiftClk) disable iff (!rst_n)
        !word_latch_strobe_n |=> linkShift_ff[21:1] == $past(linkShift_ff[20:0]))
        else $error("oldest bit not dropped");
    AST_COMMIT: assert property (commit ##1 clkEn ##1 clkEn
        |-> regFile_ff[0] == $past(regFile_ff[0]) || $past(wrAddr, 1) == `REG_MAIN)
        else $error("main register changed without its address");
    AST_RFSEL: assert property (wrRf2 |=> rfSelect)
        else $error("RF2 not selected after its write");
    AST_TUNE: assert property ($rose(nxt_ifPow) |-> ##2 ifTuning)
        else $error("IF tuning not started at power-up");
    AST_SLEEP: assert property (!sleepSync_ff |=> !rfPowered && !ifPowered)
        else $error("powered while sleep pin low");
    AST_WARN: assert property (rfTuning || ifTuning |=> lock_warning_n)
        else $error("warning low during tuning");
    AST_LIMIT: assert property (ifLoopClosed && limitSync_ff[0] |=> lock_warning_n)
        else $error("warning low near range limit");
    AST_IFDIV: assert property (wrHot[`REG_MAIN] ##1 clkEn
        |=> ifDivSel == $past(wrData[`MAIN_IFDIV_LSB-`DATA_LSB+4 +: 2], 2))
        else $error("IF divider not taken");
    AST_IGNORE: assert property (frameValid_ff && wrAddr > 4'h8 |=> $stable(rfSelect))
        else $error("unimplemented address had an effect");
    AST_AUX: assert property (regFile_ff[0][13:12] == 2'h1 |=> auxiliary_pin == $past(warn_ff))
        else $error("aux pin does not follow warning");

    COV_FRAME: cover property (frameValid_ff);
    COV_RF2: cover property ($rose(rfSelect));
    COV_WARN_LOW: cover property ($fell(lock_warning_n));
    COV_AUX: cover property ($rose(auxiliary_pin));

endmodule : synth_serial_program_and_tune

// ==== host_link_model.sv ====
// Purpose: host side of the serial programming link
// Assumes: 6 ns shift clock, data changes on its fall
// Notes:   clock stands still outside frames except in noise and one pulse in reset; released data line inverts
`timescale 1ns/100ps
module host_link_model
    import synth_pkg::*;
(
    output logic shiftClk,
    output logic serialOut,
    output logic strobeOut_n
);
    initial begin
        shiftClk    = 1'b0;
        serialOut   = 1'b0;
        strobeOut_n = 1'b1;
    end

    // ************************************************************
    // link cycles
    // ************************************************************
    task automatic pulse();
        #3 shiftClk = 1'b1;
        #3 shiftClk = 1'b0;
    endtask : pulse

    task automatic clk_bit(input logic b);
        serialOut = b;
        pulse();
    endtask : clk_bit

    // low nbits of the frame, msb first, leading junk first
    task automatic send(input frame_t f, input int extra, input int nbits);
        int i;
        #1.3 strobeOut_n = 1'b0;
        for (i = 0; i < extra; i++) clk_bit(i[0]);
        for (i = nbits - 1; i >= 0; i--) clk_bit(f[i]);
        #2 strobeOut_n = 1'b1;
        serialOut = ~serialOut;
        // clock held still while the strobe rise is synchronised
        #40;
    endtask : send

    // clocking with strobe high, must be ignored
    task automatic noise(input frame_t f);
        int i;
        for (i = 21; i >= 0; i--) clk_bit(f[i]);
        serialOut = ~serialOut;
    endtask : noise
endmodule : host_link_model

// ==== tb.sv ====
// Purpose: self-checking bench of the programming and tuning block
// Assumes: fixed waits follow the commit and sync latencies of the block
// Notes:   clkEn high except for one frame in t_quiet_and_unmapped
`timescale 1ns/100ps
`include "synth_consts.svh"
module tb
    import synth_pkg::*;
;
    logic       sys_clk;
    logic       rst_n;
    logic       clkEn;
    logic       updateTick;
    logic       sleep_pin_n;
    logic       ifNearLimit;
    logic       rfNearLimit;
    logic       shiftClk;
    logic       serialLine;
    logic       strobe_n;
    logic       rfSelect;
    logic       rfPowered;
    logic       ifPowered;
    logic [1:0] ifDivSel;
    logic       rfTuning;
    logic       ifTuning;
    logic       rfLoopClosed;
    logic       ifLoopClosed;
    logic       lockWarn_n;
    logic       auxPin;
    int         err_total;
    int         n_checks;

    host_link_model host (.shiftClk(shiftClk), .serialOut(serialLine), .strobeOut_n(strobe_n));

    synth_serial_program_and_tune DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .shiftClk(shiftClk),
        .serial_in_line(serialLine), .word_latch_strobe_n(strobe_n),
        .sleep_pin_n(sleep_pin_n), .updateTick(updateTick), .ifNearLimit(ifNearLimit),
        .rfNearLimit(rfNearLimit), .rfSelect(rfSelect), .rfPowered(rfPowered),
        .ifPowered(ifPowered), .ifDivSel(ifDivSel), .rfTuning(rfTuning),
        .ifTuning(ifTuning), .rfLoopClosed(rfLoopClosed), .ifLoopClosed(ifLoopClosed),
        .lock_warning_n(lockWarn_n), .auxiliary_pin(auxPin));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    function automatic frame_t mk(input logic [3:0] a, input regData_t d);
        return {d, a};
    endfunction : mk

    task automatic commit(input frame_t f, input int extra);
        host.send(f, extra, 22);
        repeat (8) @(negedge sys_clk);
    endtask : commit

    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge sys_clk) updateTick = 1'b1;
            @(negedge sys_clk) updateTick = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
    endtask : ticks

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        check("rfPowered", 2'(rfPowered), 2'h0);
        check("ifPowered", 2'(ifPowered), 2'h0);
        check("ifDivSel", ifDivSel, 2'h0);
        check("tuning", {rfTuning, ifTuning}, 2'h0);
        check("lockWarn_n", 2'(lockWarn_n), 2'h1);
    endtask : t_reset

    task automatic t_rf_select();
        logic [3:0] adr [4] = '{`REG_N_RF2, `REG_R_RF1, `REG_R_RF2, `REG_N_RF1};
        int i;
        for (i = 0; i < 4; i++) begin
            commit(mk(adr[i], 18'h0ABCD), 0);
            check("rfSelect", 2'(rfSelect), {1'b0, ~i[0]});
        end
    endtask : t_rf_select

    task automatic t_if_div();
        int i;
        for (i = 0; i < 4; i++) begin
            // last pass adds leading junk bits
            commit(mk(`REG_MAIN, {4'h0, 2'h1, i[1:0], 10'h000}), (i == 3) ? 5 : 0);
            check("ifDivSel", ifDivSel, i[1:0]);
        end
    endtask : t_if_div

    task automatic t_quiet_and_unmapped();
        int a;
        host.noise(mk(`REG_MAIN, 18'h01400));
        host.send(mk(`REG_MAIN, 18'h00000), 0, 0);
        repeat (8) @(negedge sys_clk);
        check("ifDivSel_quiet", ifDivSel, 2'h3);
        for (a = 9; a < 16; a++) commit(mk(a[3:0], 18'h01000), 0);
        check("ifDivSel_unmapped", ifDivSel, 2'h3);
        check("auxPin", 2'(auxPin), 2'h1);
        // clock enable low: frame shifts in but is never committed, sys_clk logic holds
        clkEn = 1'b0;
        commit(mk(`REG_MAIN, 18'h01400), 0);
        check("ifDivSel_frozen", ifDivSel, 2'h3);
        clkEn = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("ifDivSel_resumed", ifDivSel, 2'h3);
    endtask : t_quiet_and_unmapped

    task automatic t_tune();
        commit(mk(`REG_PWR, 18'h00003), 0);
        check("powered", {rfPowered, ifPowered}, 2'h3);
        check("tuning", {rfTuning, ifTuning}, 2'h3);
        ticks(12);
        check("tuning_12", {rfTuning, ifTuning}, 2'h3);
        check("lockWarn_n", 2'(lockWarn_n), 2'h1);
        ticks(1);
        repeat (3) @(negedge sys_clk);
        check("tuning_13", {rfTuning, ifTuning}, 2'h0);
        check("loopClosed", {rfLoopClosed, ifLoopClosed}, 2'h3);
        check("lockWarn_n", 2'(lockWarn_n), 2'h0);
        check("auxPin", 2'(auxPin), 2'h0);
        ifNearLimit = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("lockWarn_n_if", 2'(lockWarn_n), 2'h1);
        check("auxPin", 2'(auxPin), 2'h1);
        ifNearLimit = 1'b0;
        // warning seen: host retunes both
        commit(mk(`REG_N_IF, 18'h00123), 0);
        check("tuning_if", {rfTuning, ifTuning}, 2'h1);
        check("lockWarn_n", 2'(lockWarn_n), 2'h1);
        commit(mk(`REG_N_RF1, 18'h00456), 0);
        check("tuning_rf", 2'(rfTuning), 2'h1);
        ticks(13);
        repeat (3) @(negedge sys_clk);
        check("loopClosed", {rfLoopClosed, ifLoopClosed}, 2'h3);
        check("lockWarn_n", 2'(lockWarn_n), 2'h0);
        rfNearLimit = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("lockWarn_n_rf", 2'(lockWarn_n), 2'h1);
        rfNearLimit = 1'b0;
        repeat (6) @(negedge sys_clk);
        check("lockWarn_n", 2'(lockWarn_n), 2'h0);
    endtask : t_tune

    task automatic t_sleep();
        sleep_pin_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        check("powered_sleep", {rfPowered, ifPowered}, 2'h0);
        commit(mk(`REG_R_RF2, 18'h00020), 0);
        check("rfSelect_sleep", 2'(rfSelect), 2'h1);
        sleep_pin_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        check("powered_wake", {rfPowered, ifPowered}, 2'h3);
        check("tuning_wake", {rfTuning, ifTuning}, 2'h3);
    endtask : t_sleep

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        err_total   = 0;
        n_checks    = 0;
        rst_n       = 1'b0;
        clkEn       = 1'b1;
        updateTick  = 1'b0;
        sleep_pin_n = 1'b1;
        ifNearLimit = 1'b0;
        rfNearLimit = 1'b0;
        host.pulse();
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_rf_select();
        t_if_div();
        t_quiet_and_unmapped();
        t_tune();
        t_sleep();
        conclude();
    end

    initial begin
        #300000;
        err_total++;
        $display("Error watchdog expired");
        conclude();
    end
endmodule : tb
